// File: hdl/ppd_consts.svh
/*
 Offsets, field positions, masks and reset values of the port pin control block.
 Assumes an 8-bit register port with byte offsets.
*/
`ifndef PPD_CONSTS_SVH
`define PPD_CONSTS_SVH

`define PPD_OFF_PA_ADDR 8'h02
`define PPD_OFF_PB_ADDR 8'h03
`define PPD_OFF_PA_DRV 8'h08
`define PPD_OFF_PB_DRV 8'h09
`define PPD_OFF_PA_OE 8'h0c
`define PPD_OFF_PB_OE 8'h0d
`define PPD_OFF_PC_DRV 8'h16
`define PPD_OFF_PC_OE 8'h1a
`define PPD_OFF_MAP_CTRL 8'h2c
`define PPD_MAP_PIO_BIT 7
`define PPD_REG_RESET 8'h00
`define PPD_OD_MASK 8'hf0
`define PPD_SLEW_MASK 8'h0f
`define PPD_PC_GEN_MASK 8'h9c
`define PPD_PC_JTAG_MASK 8'h63
`define PPD_PC_ISP_STAT_BIT 3
`define PPD_PC_ISP_ERR_BIT 4

`endif

// File: hdl/ppd_pkg.sv
/*
 Types shared by the port pin control block.
 Assumes the constants header is included by users that need numbers.
*/
package ppd_pkg;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } ppd_drive_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } ppd_bus_req_t;

endpackage

// File: hdl/ppd_port_ctrl.sv
/*
 Port pin control: latched address out, peripheral data repeater, JTAG pins,
 drive type selection and output enable readback.
 Assumes one clock, core signals synchronous to it, pins resolved outside.
*/
// Design decision made here: strobed register access.
// Function
// - Secondary address select bit 1 drives latched address bit; 0 keeps I/O.
// - Low or high byte on secondary port; byte choice fixed by parameter.
// - Primary address select register at 02h, bit n gives An on pin n.
// - Latched address captured from multiplexed bus on address latch strobe.
// - Repeater carries D0-D7 only, direction from core read and write strobes.
// - Repeater active only when either of two ORed peripheral selects hits.
// - Peripheral selects qualified with program store strobe high.
// - Repeater enabled by bit 7 of memory mapping control register.
// - Range compare includes page number when paging is used.
// - Peripheral I/O designation moves all eight primary pins together.
// - Designated primary port serves no other function.
// - Four boundary scan pins on third port are JTAG only.
// - Two optional third-port pins carry ISP status and error.
// - Drive types writable at run time, default push-pull normal slew.
// - Primary/secondary drive bits 7-4 open drain, bits 3-0 fast slew.
// - Third-port drive has open drain on bits 7,4,3,2 only.
// - Address select and drive registers reset to zero.
// - Enable readback returns each primary/secondary pin's final output enable at any time; third port bits 7,4,3,2 only.
// - Final enable from product term, direction or repeater (primary only).
`include "ppd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ppd_port_ctrl #(
   parameter logic PRIMARY_PIO = 1'b0,
   parameter logic SEC_HIGH_BYTE = 1'b0,
   parameter logic ISP_STATUS_PINS = 1'b0,
   parameter logic USE_PAGING = 1'b0,
   parameter logic [15:0] SEL0_BASE = 16'h8000,
   parameter logic [15:0] SEL0_LIMIT = 16'h80ff,
   parameter logic [7:0] SEL0_PAGE = 8'h00,
   parameter logic [15:0] SEL1_BASE = 16'hffff,
   parameter logic [15:0] SEL1_LIMIT = 16'h0000,
   parameter logic [7:0] SEL1_PAGE = 8'h00
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire ppd_pkg::ppd_bus_req_t busReq,
   output logic [7:0] regRdata,
   input wire logic ale,
   input wire logic [15:0] adBus,
   input wire logic [7:0] pageNum,
   input wire logic programStoreStrobeN,
   input wire logic rdN,
   input wire logic wrN,
   input wire logic [7:0] coreDataOut,
   output logic [7:0] coreDataIn,
   output logic coreDataValid,
   input wire logic [7:0] otherOutA,
   input wire logic [7:0] otherOeA,
   input wire logic [7:0] otherOutB,
   input wire logic [7:0] otherOeB,
   input wire logic [7:0] otherOutC,
   input wire logic [7:0] otherOeC,
   input wire logic [7:0] jtagOutC,
   input wire logic [7:0] jtagOeC,
   input wire logic ispStatus,
   input wire logic ispError,
   input wire logic [7:0] pinAIn,
   output ppd_pkg::ppd_drive_t pinA,
   output ppd_pkg::ppd_drive_t pinB,
   output ppd_pkg::ppd_drive_t pinC,
   output logic [3:0] slewFastA,
   output logic [3:0] slewFastB
);
   import ppd_pkg::*;

   logic [7:0] addrSelA_q;
   logic [7:0] addrSelB_q;
   logic [7:0] driveA_q;
   logic [7:0] driveB_q;
   logic [7:0] driveC_q;
   logic pioEn_q;
   logic [15:0] latchedAddr_q;
   logic [7:0] regRdata_q;
   logic [7:0] coreDataIn_q;
   logic coreDataValid_q;
   ppd_drive_t pinA_q;
   ppd_drive_t pinB_q;
   ppd_drive_t pinC_q;

   // Address window test, page compared only when paging is used
   function automatic logic inRange(input logic [15:0] addr, input logic [7:0] page,
                                    input logic [15:0] base, input logic [15:0] limit,
                                    input logic [7:0] selPage);
      inRange = (addr >= base) && (addr <= limit) && (!USE_PAGING || page == selPage);
   endfunction

   // Open drain pins release instead of driving high
   function automatic ppd_drive_t applyOd(input logic [7:0] out, input logic [7:0] oe,
                                          input logic [7:0] od);
      applyOd.out = out;
      applyOd.oe = oe & ~(od & out);
   endfunction

   wire logic wrA = busReq.we && busReq.addr == `PPD_OFF_PA_ADDR;
   wire logic wrB = busReq.we && busReq.addr == `PPD_OFF_PB_ADDR;
   wire logic wrDrvA = busReq.we && busReq.addr == `PPD_OFF_PA_DRV;
   wire logic wrDrvB = busReq.we && busReq.addr == `PPD_OFF_PB_DRV;
   wire logic wrDrvC = busReq.we && busReq.addr == `PPD_OFF_PC_DRV;
   wire logic wrMap = busReq.we && busReq.addr == `PPD_OFF_MAP_CTRL;

   wire logic periphSelectZero = programStoreStrobeN &&
      inRange(latchedAddr_q, pageNum, SEL0_BASE, SEL0_LIMIT, SEL0_PAGE);
   wire logic periphSelectOne = programStoreStrobeN &&
      inRange(latchedAddr_q, pageNum, SEL1_BASE, SEL1_LIMIT, SEL1_PAGE);
   wire logic repActive = PRIMARY_PIO && pioEn_q && (periphSelectZero || periphSelectOne);
   wire logic repWrite = repActive && !wrN;
   wire logic repRead = repActive && !rdN;

   wire logic [7:0] secAddr = SEC_HIGH_BYTE ? latchedAddr_q[15:8] : latchedAddr_q[7:0];

   wire logic [7:0] nextOutB = (addrSelB_q & secAddr) | (~addrSelB_q & otherOutB);
   wire logic [7:0] nextOeB = addrSelB_q | otherOeB;

   wire logic [7:0] genOutA = (addrSelA_q & latchedAddr_q[7:0]) | (~addrSelA_q & otherOutA);
   wire logic [7:0] genOeA = addrSelA_q | otherOeA;
   wire logic [7:0] nextOutA = PRIMARY_PIO ? coreDataOut : genOutA;
   wire logic [7:0] nextOeA = PRIMARY_PIO ? {8{repWrite}} : genOeA;

   wire logic [7:0] ispOut = {3'h0, ispError, ispStatus, 3'h0};
   wire logic [7:0] ispMask = ISP_STATUS_PINS ? 8'h18 : 8'h00;
   wire logic [7:0] genMaskC = `PPD_PC_GEN_MASK & ~ispMask;
   wire logic [7:0] nextOutC = (jtagOutC & `PPD_PC_JTAG_MASK) | (ispOut & ispMask) |
      (otherOutC & genMaskC);
   wire logic [7:0] nextOeC = (jtagOeC & `PPD_PC_JTAG_MASK) | ispMask | (otherOeC & genMaskC);

   wire ppd_drive_t finalA = applyOd(nextOutA, nextOeA, driveA_q & `PPD_OD_MASK);
   wire ppd_drive_t finalB = applyOd(nextOutB, nextOeB, driveB_q & `PPD_OD_MASK);
   wire ppd_drive_t finalC = applyOd(nextOutC, nextOeC, driveC_q);

   wire logic [7:0] rdMux =
      (busReq.addr == `PPD_OFF_PA_ADDR) ? addrSelA_q :
      (busReq.addr == `PPD_OFF_PB_ADDR) ? addrSelB_q :
      (busReq.addr == `PPD_OFF_PA_DRV) ? driveA_q :
      (busReq.addr == `PPD_OFF_PB_DRV) ? driveB_q :
      (busReq.addr == `PPD_OFF_PC_DRV) ? driveC_q :
      (busReq.addr == `PPD_OFF_PA_OE) ? pinA_q.oe :
      (busReq.addr == `PPD_OFF_PB_OE) ? pinB_q.oe :
      (busReq.addr == `PPD_OFF_PC_OE) ? (pinC_q.oe & `PPD_PC_GEN_MASK) :
      (busReq.addr == `PPD_OFF_MAP_CTRL) ? {pioEn_q, 7'h00} : 8'h00;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         addrSelA_q <= `PPD_REG_RESET;
         addrSelB_q <= `PPD_REG_RESET;
         driveA_q <= `PPD_REG_RESET;
         driveB_q <= `PPD_REG_RESET;
         driveC_q <= `PPD_REG_RESET;
         pioEn_q <= 1'b0;
      end else begin
         if (wrA) begin
            addrSelA_q <= busReq.wdata;
         end
         if (wrB) begin
            addrSelB_q <= busReq.wdata;
         end
         if (wrDrvA) begin
            driveA_q <= busReq.wdata;
         end
         if (wrDrvB) begin
            driveB_q <= busReq.wdata;
         end
         if (wrDrvC) begin
            driveC_q <= busReq.wdata & `PPD_PC_GEN_MASK;
         end
         if (wrMap) begin
            pioEn_q <= busReq.wdata[`PPD_MAP_PIO_BIT];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         latchedAddr_q <= 16'h0000;
      end else if (ale) begin
         latchedAddr_q <= adBus;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         regRdata_q <= 8'h00;
      end else begin
         regRdata_q <= busReq.re ? rdMux : 8'h00;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         coreDataIn_q <= 8'h00;
         coreDataValid_q <= 1'b0;
      end else begin
         coreDataIn_q <= repRead ? pinAIn : 8'h00;
         coreDataValid_q <= repRead;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pinA_q <= '0;
         pinB_q <= '0;
         pinC_q <= '0;
      end else begin
         pinA_q <= finalA;
         pinB_q <= finalB;
         pinC_q <= finalC;
      end
   end

   assign regRdata = regRdata_q;
   assign coreDataIn = coreDataIn_q;
   assign coreDataValid = coreDataValid_q;
   assign pinA = pinA_q;
   assign pinB = pinB_q;
   assign pinC = pinC_q;
   assign slewFastA = driveA_q[3:0];
   assign slewFastB = driveB_q[3:0];

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_rep_read;
      repRead ##1 coreDataValid;
   endsequence

   a_sec_addr_pin: assert property (addrSelB_q[0] && $stable(addrSelB_q) |=>
      pinB.oe[0] && pinB.out[0] == $past(secAddr[0]))
      else $error("secondary address pin not driven");
   a_pri_addr_pin: assert property (!PRIMARY_PIO && addrSelA_q[1] |=>
      pinA.oe[1] && pinA.out[1] == $past(latchedAddr_q[1]))
      else $error("primary address pin not driven");
   a_latch_capture: assert property (ale |=> latchedAddr_q == $past(adBus))
      else $error("address not latched");
   a_rep_write: assert property (repWrite |=> pinA.out == $past(coreDataOut))
      else $error("repeater write data wrong");
   a_rep_read: assert property (s_rep_read |->
      coreDataIn == $past(pinAIn) && pinA.oe == 8'h00)
      else $error("repeater read wrong");
   a_rep_fetch: assert property (!programStoreStrobeN |-> !repActive)
      else $error("repeater active in fetch");
   a_rep_gate: assert property (!pioEn_q |=> !coreDataValid)
      else $error("repeater active while disabled");
   a_pio_whole: assert property (PRIMARY_PIO && !repWrite |=> pinA.oe == 8'h00)
      else $error("designated port driven by other source");
   a_jtag_pins: assert property (##1 (pinC.oe & 8'h63) == ($past(jtagOeC) & 8'h63))
      else $error("jtag pin enable wrong");
   a_od_release: assert property ($past(driveB_q[7]) |-> !(pinB.oe[7] && pinB.out[7]))
      else $error("open drain pin driven high");
   a_drv_c_mask: assert property ((driveC_q & 8'h63) == 8'h00)
      else $error("reserved drive bits set");
   a_drive_reset: assert property ($rose(rst_n) |->
      driveA_q == 8'h00 && addrSelB_q == 8'h00)
      else $error("registers not cleared");
   a_oe_readback: assert property (busReq.re && busReq.addr == 8'h0d |=>
      regRdata == $past(pinB.oe))
      else $error("enable readback wrong");

   // Pin and register checks
   a_sec_io_pin: assert property (
      !addrSelB_q[2] |=> pinB.out[2] == $past(otherOutB[2]))
      else $error("secondary io pin wrong");
   a_sec_high_byte: assert property (
      SEC_HIGH_BYTE && addrSelB_q[7] |=> pinB.out[7] == $past(latchedAddr_q[15]))
      else $error("secondary high address bit wrong");
   a_sec_low_byte: assert property (
      !SEC_HIGH_BYTE && addrSelB_q[7] |=> pinB.out[7] == $past(latchedAddr_q[7]))
      else $error("secondary low address bit wrong");
   a_pri_io_pin: assert property (
      !PRIMARY_PIO && !addrSelA_q[4] |=> pinA.out[4] == $past(otherOutA[4]))
      else $error("primary io pin wrong");
   a_latch_hold: assert property (
      !ale |=> $stable(latchedAddr_q))
      else $error("latched address changed without strobe");
   a_rep_write_oe: assert property (
      repWrite && driveA_q[7:4] == 4'h0 |=> pinA.oe == 8'hff)
      else $error("repeater write not driving");
   a_rep_read_data: assert property (
      repRead |=> coreDataValid && coreDataIn == $past(pinAIn))
      else $error("repeater read data wrong");
   a_rep_idle_data: assert property (
      !repRead |=> !coreDataValid && coreDataIn == 8'h00)
      else $error("read path active while idle");
   a_rep_no_sel: assert property (
      !periphSelectZero && !periphSelectOne |-> !repActive)
      else $error("repeater active outside windows");
   a_rep_sel_one: assert property (
      PRIMARY_PIO && pioEn_q && periphSelectOne |-> repActive)
      else $error("second select ignored");
   a_rep_page: assert property (
      USE_PAGING && pageNum != SEL0_PAGE && pageNum != SEL1_PAGE |-> !repActive)
      else $error("repeater active on wrong page");
   a_rep_enable_off: assert property (
      !pioEn_q |-> !repActive)
      else $error("repeater active while disabled");
   a_map_write: assert property (
      wrMap |=> pioEn_q == $past(busReq.wdata[`PPD_MAP_PIO_BIT]))
      else $error("repeater enable not written");
   a_pio_all_pins: assert property (
      PRIMARY_PIO |=> pinA.oe == 8'h00 || (pinA.oe | $past(driveA_q & `PPD_OD_MASK)) == 8'hff)
      else $error("primary pins not switched together");
   a_pio_data_only: assert property (
      PRIMARY_PIO |=> pinA.out == $past(coreDataOut))
      else $error("designated port carries other data");
   a_jtag_out: assert property (
      1'b1 |=> (pinC.out & `PPD_PC_JTAG_MASK) == $past(jtagOutC & `PPD_PC_JTAG_MASK))
      else $error("jtag pin data wrong");
   a_isp_pins: assert property (
      ISP_STATUS_PINS |=> pinC.out[3] == $past(ispStatus) && pinC.out[4] == $past(ispError))
      else $error("isp status pins wrong");
   a_isp_off: assert property (
      !ISP_STATUS_PINS |=> pinC.out[3] == $past(otherOutC[3]))
      else $error("third port pin wrong");
   a_drv_write: assert property (
      wrDrvA |=> driveA_q == $past(busReq.wdata))
      else $error("drive type not written");
   a_od_primary: assert property (
      $past(driveA_q[5]) |-> !(pinA.oe[5] && pinA.out[5]))
      else $error("primary open drain pin driven high");
   a_push_pull_low: assert property (
      addrSelB_q[1] || otherOeB[1] |=> pinB.oe[1])
      else $error("slew pin released");
   a_od_third: assert property (
      $past(driveC_q[2]) |-> !(pinC.oe[2] && pinC.out[2]))
      else $error("third port open drain pin driven high");
   a_reset_zero: assert property (
      $rose(rst_n) |-> driveB_q == 8'h00 && driveC_q == 8'h00 && addrSelA_q == 8'h00)
      else $error("registers not cleared");
   a_pin_reset: assert property (
      $rose(rst_n) |-> pinA.oe == 8'h00 && pinB.oe == 8'h00 && pinC.oe == 8'h00)
      else $error("pins driven after reset");
   a_oe_read_a: assert property (
      busReq.re && busReq.addr == `PPD_OFF_PA_OE |=> regRdata == $past(pinA.oe))
      else $error("primary enable readback wrong");
   a_oe_read_c: assert property (
      busReq.re && busReq.addr == `PPD_OFF_PC_OE |=>
      regRdata == ($past(pinC.oe) & `PPD_PC_GEN_MASK))
      else $error("third enable readback wrong");
   a_read_idle: assert property (
      !busReq.re |=> regRdata == 8'h00)
      else $error("read data outside read cycle");
   a_oe_source_b: assert property (
      !addrSelB_q[2] && !otherOeB[2] |=> !pinB.oe[2])
      else $error("secondary pin driven without source");
   a_idle_fallback: assert property (
      !PRIMARY_PIO && !addrSelA_q[6] && !driveA_q[6] |=> pinA.oe[6] == $past(otherOeA[6]))
      else $error("primary enable not from other source");

endmodule

`default_nettype wire

// File: tb/ppd_periph_model.sv
/*
 Parallel peripheral model on the primary port pins.
 Assumes pull-ups on the pins and active-low core strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module ppd_periph_model (
   input wire logic clock,
   input wire logic rdN,
   input wire logic wrN,
   input wire ppd_pkg::ppd_drive_t pinA,
   output logic [7:0] pinAIn
);
   import ppd_pkg::*;
   logic [7:0] store = 8'h5a;
   logic [7:0] level;
   assign level = (pinA.out & pinA.oe) | ~pinA.oe;
   always @(posedge clock) begin
      if (!wrN) begin
         store <= level;
      end
   end
   // drive on reads, else show inverse
   assign pinAIn = !rdN ? store : ~store;
endmodule
`default_nettype wire

// File: tb/ppd_port_ctrl_tb.sv
/*
 Self-checking bench of the port pin control block.
 Assumes the peripheral model on the primary port and a 100 MHz clock.
*/
`include "ppd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ppd_port_ctrl_tb;
   import ppd_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   ppd_bus_req_t busReq = '0;
   logic ale = 1'b0, programStoreStrobeN = 1'b1, rdN = 1'b1, wrN = 1'b1;
   logic ispStatus = 1'b0, ispError = 1'b0;
   logic [15:0] adBus = '0, e;
   logic [7:0] pageNum = '0, coreDataOut = '0, otherOutA = '0, otherOeA = '0;
   logic [7:0] otherOutB = '0, otherOeB = '0, otherOutC = '0, otherOeC = '0;
   logic [7:0] jtagOutC = '0, jtagOeC = '0, pinAIn, regRdata, coreDataIn, v, lat, drv, d, eo, st;
   logic coreDataValid;
   logic [3:0] slewFastA, slewFastB;
   ppd_drive_t pinA, pinB, pinC;
   int errors = 0, cmpCount = 0;
   logic [7:0] offs [9] = '{8'h02, 8'h03, 8'h08, 8'h09, 8'h16, 8'h2c, 8'h0c, 8'h0d, 8'h40};
   logic [7:0] wOff [7] = '{8'h08, 8'h09, 8'h16, 8'h03, 8'h02, 8'h2c, 8'h40};
   logic [7:0] wMask [7] = '{8'hff, 8'hff, 8'h9c, 8'hff, 8'hff, 8'h80, 8'h00};
   logic [7:0] wv [7];
   logic [15:0] cAddr [7] = '{16'h8010, 16'h8010, 16'h8010, 16'h8100, 16'h80ff, 16'h8000,
      16'h9080};
   logic [7:0] cPage [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
   logic cEn [7] = '{1, 0, 1, 1, 1, 1, 1};
   logic cPs [7] = '{1, 1, 0, 1, 1, 1, 1};
   logic cAct [7] = '{1, 0, 0, 0, 1, 0, 1};

   always #5 clock = ~clock;

   ppd_port_ctrl #(.PRIMARY_PIO(1'b1), .ISP_STATUS_PINS(1'b1), .USE_PAGING(1'b1),
      .SEL1_BASE(16'h9000), .SEL1_LIMIT(16'h90ff))
   ppd_port_ctrl_i (.clock, .rst_n, .busReq, .regRdata, .ale, .adBus, .pageNum,
      .programStoreStrobeN, .rdN, .wrN, .coreDataOut, .coreDataIn, .coreDataValid,
      .otherOutA, .otherOeA, .otherOutB, .otherOeB, .otherOutC, .otherOeC, .jtagOutC,
      .jtagOeC, .ispStatus, .ispError, .pinAIn, .pinA, .pinB, .pinC, .slewFastA, .slewFastB);

   ppd_periph_model ppd_periph_model_i (.clock, .rdN, .wrN, .pinA, .pinAIn);

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(posedge clock);
      busReq <= '{addr: a, wdata: dat, we: 1'b1, re: 1'b0};
      @(posedge clock);
      busReq <= '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clock);
      busReq <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge clock);
      busReq <= '0;
      #1 chk(regRdata, exp);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   function automatic logic [15:0] expB(logic [7:0] sel, lt, oo, oe, dr);
      logic [7:0] o;
      o = (sel & lt) | (~sel & oo);
      return {o, (sel | oe) & ~(dr & `PPD_OD_MASK & o)};
   endfunction

   function automatic logic [15:0] expC(logic [7:0] oo, oe, jo, je, dr, logic s, r);
      logic [7:0] o;
      o = (oo & 8'h84) | (jo & `PPD_PC_JTAG_MASK) | {3'h0, r, s, 3'h0};
      return {o, (oe & 8'h84 & ~(dr & o)) | (je & `PPD_PC_JTAG_MASK) | 8'h18};
   endfunction

   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      $display("mismatch at %0t: run did not finish", $time);
      close_out();
   end

   initial begin
      void'($urandom(32'h7d5241a4));
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      foreach (offs[i]) rd(offs[i], 16'h0000);
      repeat (4) begin
         foreach (wOff[i]) begin
            wv[i] = 8'($urandom);
            wr(wOff[i], wv[i]);
         end
         foreach (wOff[i]) rd(wOff[i], {8'h00, wv[i] & wMask[i]});
         chk({slewFastA, slewFastB}, {wv[0][3:0], wv[1][3:0]});
      end
      $display("test registers done");
      repeat (8) begin
         v = 8'($urandom);
         lat = 8'($urandom);
         drv = 8'($urandom);
         wr(`PPD_OFF_PB_ADDR, v);
         wr(`PPD_OFF_PB_DRV, drv);
         wr(`PPD_OFF_PC_DRV, drv & 8'h84);
         @(posedge clock);
         ale <= 1'b1;
         adBus <= {8'($urandom), lat};
         otherOutB <= 8'($urandom);
         otherOeB <= 8'($urandom);
         {otherOutC, otherOeC, jtagOutC, jtagOeC} <= 32'($urandom);
         {ispStatus, ispError} <= 2'($urandom);
         @(posedge clock);
         ale <= 1'b0;
         tick(3);
         e = expB(v, lat, otherOutB, otherOeB, drv);
         chk(pinB, e);
         wr(`PPD_OFF_PB_OE, 8'hff);
         rd(`PPD_OFF_PB_OE, e[7:0]);
         e = expC(otherOutC, otherOeC, jtagOutC, jtagOeC, drv & 8'h84, ispStatus, ispError);
         chk(pinC, e);
         rd(`PPD_OFF_PC_OE, e[7:0] & `PPD_PC_GEN_MASK);
      end
      $display("test pins done");
      drv = 8'($urandom);
      wr(`PPD_OFF_PA_DRV, drv);
      foreach (cAddr[i]) begin
         wr(`PPD_OFF_MAP_CTRL, {cEn[i], 7'h00});
         d = 8'($urandom);
         @(posedge clock);
         ale <= 1'b1;
         adBus <= cAddr[i];
         pageNum <= cPage[i];
         programStoreStrobeN <= cPs[i];
         coreDataOut <= d;
         otherOutA <= 8'($urandom);
         otherOeA <= 8'hff;
         @(posedge clock);
         ale <= 1'b0;
         wrN <= 1'b0;
         tick(3);
         eo = cAct[i] ? ~(drv & `PPD_OD_MASK & d) : 8'h00;
         st = cAct[i] ? (d & eo) | ~eo : 8'hff;
         chk(pinA, {d, eo});
         rd(`PPD_OFF_PA_OE, eo);
         @(posedge clock);
         wrN <= 1'b1;
         @(posedge clock);
         rdN <= 1'b0;
         tick(3);
         chk({pinA.oe, coreDataIn}, {8'h00, cAct[i] ? st : 8'h00});
         chk(coreDataValid, cAct[i]);
         @(posedge clock);
         rdN <= 1'b1;
      end
      $display("test repeater done");
      close_out();
   end
endmodule
`default_nettype wire
